// ===== core/mdc_config_bank.sv
// motor drive configuration register bank and the logic it steers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module mdc_config_bank
  import mdc_pkg::*;
#(
  parameter int FAST_CYCLES = FAST_START_CYCLES,
  parameter int LOCK_CYCLES = LOCK_STEP_CYCLES
) (
  input  wire logic        core_clk_in,              // 40 MHz clock
  input  wire logic        nrst_in,                  // sync reset, low
  input  wire logic [15:0] addr_in,                  // register address
  input  wire logic [7:0]  wdata_in,                 // write data
  input  wire logic        wr_in,                    // write strobe
  input  wire logic        rd_in,                    // read strobe
  output logic      [7:0]  rdata_out,                // read data
  input  wire logic        high_voltage_duty_pin_in, // duty pin, hv
  input  wire logic        low_voltage_duty_pin_in,  // duty pin, lv
  input  wire logic        enable_pin_in,            // drive enable pin
  input  wire logic        thermistor_trip_in,       // comparator pin
  input  wire logic [1:0]  observation_window_count_in, // window mode
  input  wire logic        duty_full_in,             // duty is 100%
  input  wire logic        duty_zero_in,             // duty is 0%
  input  wire logic        duty_valid_in,            // duty decoded
  input  wire logic        duty_fault_in,            // abnormal duty
  input  wire logic        bemf_detect_in,           // bemf event pulse
  input  wire logic        startup_active_in,        // in startup mode
  output logic             rotation_direction_out,   // 1 reverse
  output logic             free_run_start_select_out, // 1 open loop
  output logic             direct_duty_mode_out,     // 1 direct duty
  output logic             input_freq_range_out,     // 1 wide range
  output logic             regulator_voltage_select_out, // 1 high volt
  output logic             regulator_on_out,         // regulator on
  output logic             speed_loop_period_out,    // 1 per 120 deg
  output logic             duty_active_out,          // duty input level
  output logic             fallback_active_out,      // fallback in use
  output logic             fallback_off_out,         // fallback is off
  output logic      [2:0]  fallback_code_out,        // fallback code
  output logic             preset_duty_active_out,   // fast start
  output logic             stable_sampling_out,      // 120 deg sampling
  output logic             speed_pulse_out,          // speed pulse
  output logic      [8:0]  dead_time_cycles_out,     // dead time
  output logic      [7:0]  limit_blank_cycles_out,   // limit blanking
  output logic      [7:0]  overcurrent_blank_cycles_out, // oc persist
  output logic      [6:0]  rect_off_periods_out,     // in pulse periods
  output logic      [7:0]  reverse_blank_cycles_out, // reverse persist
  output logic             sync_rectification_out,   // complementary
  output logic             fault_indicator_out,      // duty fault report
  output logic      [9:0]  short_check_cycles_out,   // short check delay
  output logic      [3:0]  short_check_level_out,    // level code
  output logic      [1:0]  thermistor_threshold_out, // threshold code
  output logic             die_temp_level_select_out, // die temp level
  output logic             locked_rotor_out,         // locked flagged
  output logic             motor_off_out,            // power stage off
  output logic             external_thermal_error_out // thermal error
);

  // ===========================================================
  // parameter checks
  if (FAST_CYCLES < 1)
    $error("FAST_CYCLES must be at least one");
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 33554431)
    $error("LOCK_CYCLES out of range for 32-bit timers");

  // ===========================================================
  // registers
  logic [7:0] drive_mode_config;
  logic [7:0] fallback_level_config;
  logic [7:0] speed_pulse_deadtime_config;
  logic [7:0] current_mask_config;
  logic [7:0] reverse_current_config;
  logic [7:0] rectification_short_config;
  logic [7:0] lock_thermal_config;

  wire hit0 = (addr_in == MDC_DRIVE_MODE_OFS);
  wire hit1 = (addr_in == MDC_FALLBACK_OFS);
  wire hit2 = (addr_in == MDC_PULSE_DEAD_OFS);
  wire hit3 = (addr_in == MDC_CURRENT_MASK_OFS);
  wire hit4 = (addr_in == MDC_REVERSE_OFS);
  wire hit5 = (addr_in == MDC_RECT_SHORT_OFS);
  wire hit6 = (addr_in == MDC_LOCK_THERM_OFS);

  logic [7:0] next_rdata;
  always_comb begin
    if (!rd_in)
      next_rdata = MDC_REG_RESET;
    else if (hit0)
      next_rdata = drive_mode_config;
    else if (hit1)
      next_rdata = fallback_level_config;
    else if (hit2)
      next_rdata = speed_pulse_deadtime_config;
    else if (hit3)
      next_rdata = current_mask_config;
    else if (hit4)
      next_rdata = reverse_current_config;
    else if (hit5)
      next_rdata = rectification_short_config;
    else if (hit6)
      next_rdata = lock_thermal_config & MDC_LOCK_THERM_MASK;
    else
      next_rdata = MDC_REG_RESET;
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      drive_mode_config           <= MDC_REG_RESET;
      fallback_level_config       <= MDC_REG_RESET;
      speed_pulse_deadtime_config <= MDC_REG_RESET;
      current_mask_config         <= MDC_REG_RESET;
      reverse_current_config      <= MDC_REG_RESET;
      rectification_short_config  <= MDC_REG_RESET;
      lock_thermal_config         <= MDC_REG_RESET;
      rdata_out                   <= MDC_REG_RESET;
    end else begin
      rdata_out <= next_rdata;
      if (wr_in && hit0) drive_mode_config <= wdata_in;
      if (wr_in && hit1) fallback_level_config <= wdata_in;
      if (wr_in && hit2) speed_pulse_deadtime_config <= wdata_in;
      if (wr_in && hit3) current_mask_config <= wdata_in;
      if (wr_in && hit4) reverse_current_config <= wdata_in;
      if (wr_in && hit5) rectification_short_config <= wdata_in;
      if (wr_in && hit6)
        lock_thermal_config <= wdata_in & MDC_LOCK_THERM_MASK;
    end
  end

  // ===========================================================
  // field views
  wire [2:0] full_code  = fallback_level_config[MDC_FULL_LSB +: 3];
  wire [2:0] zero_code  = fallback_level_config[MDC_ZERO_LSB +: 3];
  wire [1:0] scale_code = speed_pulse_deadtime_config[MDC_SCALE_LSB +: 2];
  wire [4:0] dead_code  = speed_pulse_deadtime_config[MDC_DEAD_LSB +: 5];
  wire [3:0] limit_code = current_mask_config[MDC_HI_NIB_LSB +: 4];
  wire [3:0] oc_code    = current_mask_config[MDC_LO_NIB_LSB +: 4];
  wire [3:0] roff_code  = reverse_current_config[MDC_HI_NIB_LSB +: 4];
  wire [3:0] rmask_code = reverse_current_config[MDC_LO_NIB_LSB +: 4];
  wire [1:0] sdly_code  = rectification_short_config[MDC_SDELAY_LSB +: 2];
  wire [3:0] lock_code  = lock_thermal_config[MDC_LOCK_LSB +: 4];

  // ===========================================================
  // pin synchronisers
  localparam int NPIN = 4;
  wire  [NPIN-1:0] pin_raw = {thermistor_trip_in, enable_pin_in,
                              low_voltage_duty_pin_in,
                              high_voltage_duty_pin_in};
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end
  wire hv_duty  = pin_sync[0];
  wire lv_duty  = pin_sync[1];
  wire en_level = pin_sync[2];
  wire th_trip  = pin_sync[3];

  // ===========================================================
  // duty input, fallback, derived timings
  wire pin_pick = drive_mode_config[MDC_PINSEL_BIT] ? lv_duty
                                                    : hv_duty;
  wire next_duty_active = pin_pick ^ fallback_level_config[MDC_POL_BIT];
  wire [2:0] fb_code    = duty_full_in ? full_code : zero_code;
  wire       fb_active  = duty_full_in | duty_zero_in;
  wire       fb_off     = (fb_code == MDC_FB_OFF) || (fb_code == MDC_FB_OFF7);
  wire [8:0] next_dead  = 9'((DEAD_BASE_STEPS - int'(dead_code))
                             * STEP_CYCLES);
  wire [7:0] next_limit = 8'((int'(limit_code) + 1) * STEP_CYCLES);
  wire [7:0] next_oc    = 8'((int'(oc_code) + 1) * STEP_CYCLES);
  wire [7:0] next_rmask = 8'((REVERSE_BASE_STEPS - int'(rmask_code))
                             * STEP_CYCLES);
  wire [6:0] next_roff  = 7'((int'(roff_code) + 1) * RECT_OFF_UNIT);
  wire [9:0] next_sdly  = 10'((int'(sdly_code) + 1) * SHORT_STEP_CYCLES);
  wire       next_stable = speed_pulse_deadtime_config[MDC_STABLE_BIT]
                           && (observation_window_count_in == 2'b00);
  wire       next_fault = duty_fault_in
                          && !rectification_short_config[MDC_FAULT_BIT];

  // ===========================================================
  // speed pulse scaling: period in bemf detections is 2, 4, 3, 6
  logic [2:0] sp_count;
  wire  [2:0] sp_period = (scale_code == 2'd0) ? 3'd2 :
                          (scale_code == 2'd1) ? 3'd4 :
                          (scale_code == 2'd2) ? 3'd3 : 3'd6;
  wire  [2:0] sp_half   = 3'((4'(sp_period) + 4'd1) >> 1);
  wire  [2:0] next_sp_count = (sp_count + 3'd1 >= sp_period) ? 3'd0
                                                            : sp_count + 3'd1;

  // ===========================================================
  // fast startup bridge
  logic        en_prev;
  logic [31:0] fast_count;
  wire         en_rise = en_level && !en_prev;
  wire         fast_run = (fast_count != 32'd0);

  // ===========================================================
  // locked rotor timer
  mdc_lock_state_t lr_state;
  logic [31:0]     lr_count;
  wire  [31:0] lr_detect  = 32'(LOCK_CYCLES) * (32'(lock_code) + 32'd1);
  wire  [31:0] lr_restart = lr_detect << LOCK_RESTART_SHIFT;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      lr_state   <= MDC_LR_IDLE;
      lr_count   <= 32'd0;
      en_prev    <= 1'b0;
      fast_count <= 32'd0;
      sp_count   <= 3'd0;
    end else begin
      en_prev <= en_level;
      if (!en_level || !fallback_level_config[MDC_FAST_BIT] || duty_valid_in)
        fast_count <= 32'd0;
      else if (en_rise)
        fast_count <= 32'(FAST_CYCLES);
      else if (fast_run)
        fast_count <= fast_count - 32'd1;
      if (bemf_detect_in)
        sp_count <= next_sp_count;
      case (lr_state)
        MDC_LR_IDLE: begin
          lr_count <= 32'd0;
          if (startup_active_in && !bemf_detect_in)
            lr_state <= MDC_LR_COUNT;
        end
        MDC_LR_COUNT: begin
          if (bemf_detect_in || !startup_active_in) begin
            lr_state <= MDC_LR_IDLE;
            lr_count <= 32'd0;
          end else if (lr_count + 32'd1 >= lr_detect) begin
            lr_state <= MDC_LR_LOCKED;
            lr_count <= 32'd0;
          end else
            lr_count <= lr_count + 32'd1;
        end
        MDC_LR_LOCKED: begin
          if (lr_count + 32'd1 >= lr_restart) begin
            lr_state <= MDC_LR_IDLE;
            lr_count <= 32'd0;
          end else
            lr_count <= lr_count + 32'd1;
        end
        default: lr_state <= MDC_LR_IDLE;
      endcase
    end
  end

  // ===========================================================
  // registered outputs
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rotation_direction_out       <= 1'b0;
      free_run_start_select_out    <= 1'b0;
      direct_duty_mode_out         <= 1'b0;
      input_freq_range_out         <= 1'b0;
      regulator_voltage_select_out <= 1'b0;
      regulator_on_out             <= 1'b0;
      speed_loop_period_out        <= 1'b0;
      duty_active_out              <= 1'b0;
      fallback_active_out          <= 1'b0;
      fallback_off_out             <= 1'b0;
      fallback_code_out            <= 3'd0;
      preset_duty_active_out       <= 1'b0;
      stable_sampling_out          <= 1'b0;
      speed_pulse_out              <= 1'b0;
      dead_time_cycles_out         <= 9'd0;
      limit_blank_cycles_out       <= 8'd0;
      overcurrent_blank_cycles_out <= 8'd0;
      rect_off_periods_out         <= 7'd0;
      reverse_blank_cycles_out     <= 8'd0;
      sync_rectification_out       <= 1'b0;
      fault_indicator_out          <= 1'b0;
      short_check_cycles_out       <= 10'd0;
      short_check_level_out        <= 4'd0;
      thermistor_threshold_out     <= 2'd0;
      die_temp_level_select_out    <= 1'b0;
      locked_rotor_out             <= 1'b0;
      motor_off_out                <= 1'b0;
      external_thermal_error_out   <= 1'b0;
    end else begin
      rotation_direction_out       <= drive_mode_config[MDC_DIR_BIT];
      free_run_start_select_out    <= drive_mode_config[MDC_FREERUN_BIT];
      direct_duty_mode_out         <= drive_mode_config[MDC_DIRECT_BIT];
      input_freq_range_out         <= drive_mode_config[MDC_FREQ_BIT];
      regulator_voltage_select_out <= drive_mode_config[MDC_REGV_BIT];
      regulator_on_out             <= drive_mode_config[MDC_REGON_BIT];
      speed_loop_period_out        <= drive_mode_config[MDC_LOOP_BIT];
      duty_active_out              <= next_duty_active;
      fallback_active_out          <= fb_active;
      fallback_off_out             <= fb_active && fb_off;
      fallback_code_out            <= fb_off ? MDC_FB_OFF : fb_code;
      preset_duty_active_out       <= fast_run;
      stable_sampling_out          <= next_stable;
      speed_pulse_out              <= (sp_count < sp_half);
      dead_time_cycles_out         <= next_dead;
      limit_blank_cycles_out       <= next_limit;
      overcurrent_blank_cycles_out <= next_oc;
      rect_off_periods_out         <= next_roff;
      reverse_blank_cycles_out     <= next_rmask;
      sync_rectification_out       <= !rectification_short_config[MDC_SYNC_N_BIT];
      fault_indicator_out          <= next_fault;
      short_check_cycles_out       <= next_sdly;
      short_check_level_out        <= rectification_short_config[MDC_SLEVEL_LSB +: 4];
      thermistor_threshold_out     <= lock_thermal_config[MDC_THERM_LSB +: 2];
      die_temp_level_select_out    <= lock_thermal_config[MDC_DIETEMP_BIT];
      locked_rotor_out             <= (lr_state == MDC_LR_LOCKED);
      motor_off_out                <= (lr_state == MDC_LR_LOCKED) || th_trip;
      external_thermal_error_out   <= th_trip;
    end
  end

endmodule

// ===== core/mdc_pkg.sv
// constants for the motor drive configuration register bank
package mdc_pkg;

  // ===========================================================
  // register map
  localparam logic [15:0] MDC_DRIVE_MODE_OFS   = 16'h0100;
  localparam logic [15:0] MDC_FALLBACK_OFS     = 16'h0101;
  localparam logic [15:0] MDC_PULSE_DEAD_OFS   = 16'h0102;
  localparam logic [15:0] MDC_CURRENT_MASK_OFS = 16'h0103;
  localparam logic [15:0] MDC_REVERSE_OFS      = 16'h0104;
  localparam logic [15:0] MDC_RECT_SHORT_OFS   = 16'h0105;
  localparam logic [15:0] MDC_LOCK_THERM_OFS   = 16'h0106;
  localparam logic [7:0]  MDC_REG_RESET        = 8'h00;
  localparam logic [7:0]  MDC_LOCK_THERM_MASK  = 8'h7F;

  // ===========================================================
  // field positions
  localparam int MDC_DIR_BIT      = 7;
  localparam int MDC_FREERUN_BIT  = 6;
  localparam int MDC_DIRECT_BIT   = 5;
  localparam int MDC_FREQ_BIT     = 4;
  localparam int MDC_REGV_BIT     = 3;
  localparam int MDC_REGON_BIT    = 2;
  localparam int MDC_LOOP_BIT     = 1;
  localparam int MDC_PINSEL_BIT   = 0;
  localparam int MDC_FULL_LSB     = 5;
  localparam int MDC_ZERO_LSB     = 2;
  localparam int MDC_FAST_BIT     = 1;
  localparam int MDC_POL_BIT      = 0;
  localparam int MDC_STABLE_BIT   = 7;
  localparam int MDC_SCALE_LSB    = 5;
  localparam int MDC_DEAD_LSB     = 0;
  localparam int MDC_HI_NIB_LSB   = 4;
  localparam int MDC_LO_NIB_LSB   = 0;
  localparam int MDC_SYNC_N_BIT   = 7;
  localparam int MDC_FAULT_BIT    = 6;
  localparam int MDC_SDELAY_LSB   = 4;
  localparam int MDC_SLEVEL_LSB   = 0;
  localparam int MDC_LOCK_LSB     = 3;
  localparam int MDC_THERM_LSB    = 1;
  localparam int MDC_DIETEMP_BIT  = 0;

  // ===========================================================
  // fallback codes
  localparam logic [2:0] MDC_FB_OFF  = 3'h0;
  localparam logic [2:0] MDC_FB_OFF7 = 3'h7;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS      = 25;
  localparam int STEP_NS            = 200;
  localparam int STEP_CYCLES        = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_STEP_NS      = 3200;
  localparam int SHORT_STEP_CYCLES  = SHORT_STEP_NS / CLK_PERIOD_NS;
  localparam int DEAD_BASE_STEPS    = 32;
  localparam int REVERSE_BASE_STEPS = 16;
  localparam int RECT_OFF_UNIT      = 4;
  localparam int LOCK_RESTART_SHIFT = 3;
  localparam int FAST_START_MS      = 200;
  localparam int LOCK_STEP_MS       = 400;
  localparam int CLK_KHZ            = 1000000 / CLK_PERIOD_NS;
  localparam int FAST_START_CYCLES  = FAST_START_MS * CLK_KHZ;
  localparam int LOCK_STEP_CYCLES   = LOCK_STEP_MS * CLK_KHZ;

  // ===========================================================
  // state types
  typedef enum logic [1:0] {MDC_LR_IDLE, MDC_LR_COUNT, MDC_LR_LOCKED}
    mdc_lock_state_t;

endpackage

// ===== verif/mdc_config_bank_chk.sv
// port assertions for the motor drive configuration bank
`timescale 1ns/1ps
module mdc_config_bank_chk
  import mdc_pkg::*;
(
  input wire logic        core_clk_in,                  // clock
  input wire logic        nrst_in,                      // reset, low
  input wire logic [15:0] addr_in,                      // address
  input wire logic [7:0]  wdata_in,                     // write data
  input wire logic        wr_in,                        // write strobe
  input wire logic        rd_in,                        // read strobe
  input wire logic [7:0]  rdata_out,                    // read data
  input wire logic        duty_full_in,                 // full duty
  input wire logic        duty_zero_in,                 // zero duty
  input wire logic        duty_fault_in,                // duty fault
  input wire logic        thermistor_trip_in,           // trip pin
  input wire logic        rotation_direction_out,       // direction
  input wire logic        direct_duty_mode_out,         // direct duty
  input wire logic [8:0]  dead_time_cycles_out,         // dead time
  input wire logic [7:0]  limit_blank_cycles_out,       // limit mask
  input wire logic [7:0]  overcurrent_blank_cycles_out, // oc mask
  input wire logic [6:0]  rect_off_periods_out,         // rect off
  input wire logic [7:0]  reverse_blank_cycles_out,     // reverse mask
  input wire logic        sync_rectification_out,       // sync rect
  input wire logic        fault_indicator_out,          // fault report
  input wire logic        fallback_active_out,          // fallback
  input wire logic        external_thermal_error_out,   // thermal error
  input wire logic        motor_off_out,                // stage off
  input wire logic        locked_rotor_out              // locked
);
  // ===========================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire wr_mode = wr_in && addr_in == MDC_DRIVE_MODE_OFS;
  wire wr_dead = wr_in && addr_in == MDC_PULSE_DEAD_OFS;
  wire wr_mask = wr_in && addr_in == MDC_CURRENT_MASK_OFS;
  wire wr_rev  = wr_in && addr_in == MDC_REVERSE_OFS;
  wire wr_rect = wr_in && addr_in == MDC_RECT_SHORT_OFS;
  property p_read_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");
  property p_mode; wr_mode |-> ##2 rotation_direction_out == $past(wdata_in[7], 2)
    && direct_duty_mode_out == $past(wdata_in[5], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  property p_dead; wr_dead |-> ##2 dead_time_cycles_out ==
    9'd256 - {1'b0, $past(wdata_in[4:0], 2), 3'b000}; endproperty
  a_dead: assert property (p_dead) else $error("dead time wrong");
  property p_mask; wr_mask |-> ##2 limit_blank_cycles_out ==
    {1'b0, $past(wdata_in[7:4], 2), 3'b000} + 8'd8 && overcurrent_blank_cycles_out
    == {1'b0, $past(wdata_in[3:0], 2), 3'b000} + 8'd8; endproperty
  a_mask: assert property (p_mask) else $error("mask time wrong");
  property p_rev; wr_rev |-> ##2 rect_off_periods_out == {1'b0, $past(wdata_in[7:4],
    2), 2'b00} + 7'd4 && reverse_blank_cycles_out == 8'd128 - {1'b0,
    $past(wdata_in[3:0], 2), 3'b000}; endproperty
  a_rev: assert property (p_rev) else $error("reverse timing wrong");
  property p_sync; wr_rect |-> ##2 sync_rectification_out == !$past(wdata_in[7], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync rect wrong");
  property p_fault; !$past(duty_fault_in) |-> !fault_indicator_out; endproperty
  a_fault: assert property (p_fault) else $error("fault without cause");
  property p_fb; fallback_active_out == $past(duty_full_in || duty_zero_in);
  endproperty
  a_fb: assert property (p_fb) else $error("fallback state wrong");
  property p_therm; external_thermal_error_out == $past(thermistor_trip_in, 3);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal error wrong");
  property p_off; external_thermal_error_out || locked_rotor_out |-> motor_off_out;
  endproperty
  a_off: assert property (p_off) else $error("stage not off");
  c_read: cover property (rd_in ##1 rdata_out != 8'h00);
  c_lock: cover property ($rose(locked_rotor_out));
  c_therm: cover property ($rose(external_thermal_error_out));
endmodule
bind mdc_config_bank mdc_config_bank_chk u_chk (.*);

// ===== verif/testbench.sv
// self-checking bench for the motor drive configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t value differs", $time); end end
module testbench;
  import mdc_pkg::*;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00, rdata_out, limit_blank_cycles_out;
  logic high_voltage_duty_pin_in = 1'b1, low_voltage_duty_pin_in = 1'b0;
  logic enable_pin_in = 1'b0, thermistor_trip_in = 1'b0, duty_full_in = 1'b0;
  logic duty_zero_in = 1'b0, duty_valid_in = 1'b0, duty_fault_in = 1'b0;
  logic bemf_detect_in = 1'b0, startup_active_in = 1'b0;
  logic [1:0] observation_window_count_in = 2'h0, thermistor_threshold_out;
  logic [7:0] overcurrent_blank_cycles_out, reverse_blank_cycles_out;
  logic [8:0] dead_time_cycles_out;
  logic [9:0] short_check_cycles_out;
  logic [6:0] rect_off_periods_out;
  logic [3:0] short_check_level_out;
  logic [2:0] fallback_code_out, z;
  logic rotation_direction_out, free_run_start_select_out, direct_duty_mode_out;
  logic input_freq_range_out, regulator_voltage_select_out, regulator_on_out;
  logic speed_loop_period_out, duty_active_out, fallback_active_out, sp_q;
  logic fallback_off_out, preset_duty_active_out, stable_sampling_out;
  logic speed_pulse_out, sync_rectification_out, fault_indicator_out;
  logic die_temp_level_select_out, locked_rotor_out, motor_off_out;
  logic external_thermal_error_out;
  int miscompares = 0, num_checks = 0, edges = 0, per[4] = '{2, 4, 3, 6};
  logic [7:0] pat[7] = '{8'hDF, 8'h3C, 8'h9F, 8'hF0, 8'h0F, 8'hC5, 8'hFF};
  mdc_config_bank #(.FAST_CYCLES(20), .LOCK_CYCLES(4)) DUT (.*);
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    sp_q <= speed_pulse_out;
    if (sp_q !== speed_pulse_out) edges <= edges + 1;
  end
  // ===========================================================
  // bus tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic rst;
    @(posedge core_clk_in) nrst_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    nrst_in <= 1'b1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge core_clk_in) wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge core_clk_in) rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask
  function automatic logic [2:0] fb(input logic [2:0] c);
    return (c == 3'h7) ? 3'h0 : c;
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(25 * 10000) miscompares++;
    end_sim;
  end
  // ===========================================================
  // tests
  initial begin
    rst;
    for (int k = 0; k < 8; k++) rd(16'h0100 + 16'(k), 8'h00);
    for (int k = 0; k < 7; k++) wr(16'h0100 + 16'(k), pat[k]);
    wr(16'h0107, 8'hFF);
    for (int k = 0; k < 8; k++) rd(16'h0100 + 16'(k), (k < 7) ? pat[k] &
      ((k == 6) ? 8'h7F : 8'hFF) : 8'h00);
    `CHK({rotation_direction_out, free_run_start_select_out, direct_duty_mode_out,
      input_freq_range_out, speed_loop_period_out}, 5'b11011)
    `CHK({regulator_voltage_select_out, regulator_on_out}, 2'b11)
    `CHK({dead_time_cycles_out, limit_blank_cycles_out}, {9'd8, 8'd128})
    `CHK({overcurrent_blank_cycles_out, rect_off_periods_out,
      reverse_blank_cycles_out}, {8'd8, 7'd4, 8'd8})
    `CHK({stable_sampling_out, short_check_cycles_out}, {1'b1, 10'd128})
    `CHK(short_check_level_out, 4'h5)
    observation_window_count_in <= 2'h1;
    duty_fault_in <= 1'b1;
    cyc(2);
    `CHK({stable_sampling_out, fault_indicator_out}, 2'b00)
    wr(16'h0105, 8'h00);
    cyc(2);
    `CHK({fault_indicator_out, sync_rectification_out}, 2'b11)
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      z = ~c[2:0];
      wr(16'h0101, {c[2:0], z, 2'b00});
      {duty_full_in, duty_zero_in} <= 2'b10;
      cyc(2);
      `CHK({fallback_off_out, fallback_code_out}, {fb(c[2:0]) == 0, fb(c[2:0])})
      @(posedge core_clk_in) {duty_full_in, duty_zero_in} <= 2'b01;
      cyc(2);
      `CHK({fallback_active_out, fallback_code_out}, {1'b1, fb(z)})
    end
    duty_zero_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(16'h0100, {7'h00, i[1]});
      wr(16'h0101, {7'h00, i[0]});
      {high_voltage_duty_pin_in, low_voltage_duty_pin_in} <= {~i[2], i[2]};
      cyc(5);
      `CHK(duty_active_out, (i[1] ? i[2] : ~i[2]) ^ i[0])
    end
    $display("test duty done");
    wr(16'h0101, 8'h02);
    enable_pin_in <= 1'b1;
    cyc(7);
    `CHK(preset_duty_active_out, 1'b1)
    cyc(22);
    `CHK(preset_duty_active_out, 1'b0)
    @(posedge core_clk_in) {enable_pin_in, duty_valid_in} <= 2'b01;
    cyc(4);
    enable_pin_in <= 1'b1;
    cyc(7);
    `CHK(preset_duty_active_out, 1'b0)
    wr(16'h0106, 8'h0F);
    startup_active_in <= 1'b1;
    cyc(4);
    `CHK({locked_rotor_out, thermistor_threshold_out}, 3'b011)
    cyc(10);
    `CHK({locked_rotor_out, motor_off_out, die_temp_level_select_out}, 3'b111)
    startup_active_in <= 1'b0;
    cyc(70);
    `CHK({locked_rotor_out, motor_off_out}, 2'b00)
    thermistor_trip_in <= 1'b1;
    cyc(4);
    `CHK({external_thermal_error_out, motor_off_out}, 2'b11)
    thermistor_trip_in <= 1'b0;
    $display("test protection done");
    for (int k = 0; k < 4; k++) begin
      rst;
      wr(16'h0102, {1'b0, 2'(k), 5'h00});
      cyc(4);
      edges = 0;
      repeat (12) begin
        @(posedge core_clk_in) bemf_detect_in <= 1'b1;
        @(posedge core_clk_in) bemf_detect_in <= 1'b0;
        @(posedge core_clk_in);
      end
      cyc(4);
      `CHK(edges, 24 / per[k])
    end
    $display("test speed pulse done");
    end_sim;
  end
endmodule
